// ==== blp_pkg.sv ====
// Purpose: Shared constants and types for the block lock protection logic
// Assumes: 131 blocks (4 parameter + 127 main), top or bottom boot strap
// Notes: Offsets are word offsets within identifier space

package blp_pkg;

  // ------------------------------------------------------------
  // Command bytes
  // ------------------------------------------------------------
  localparam logic [7:0] BLP_CMD_CFG_SETUP = 8'h60;
  localparam logic [7:0] BLP_CMD_LOCK = 8'h01;
  localparam logic [7:0] BLP_CMD_UNLOCK = 8'hd0;
  localparam logic [7:0] BLP_CMD_LOCKDOWN = 8'h2f;
  localparam logic [7:0] BLP_CMD_READ_ID = 8'h90;
  localparam logic [7:0] BLP_CMD_READ_ARRAY = 8'hff;

  // ------------------------------------------------------------
  // Register offsets and fields
  // ------------------------------------------------------------
  localparam logic [7:0] BLP_OFS_LOCK_STATUS = 8'h02;
  localparam logic [7:0] BLP_OFS_PERM_WORD = 8'h80;
  localparam int BLP_BIT_LOCK_READOUT = 0;
  localparam int BLP_BIT_LOCKDOWN_READOUT = 1;
  localparam int BLP_BIT_PERM_PARAM = 2;
  localparam int BLP_BIT_PERM_MAIN0 = 3;
  localparam int BLP_BIT_PERM_MAIN2 = 5;
  localparam int BLP_BIT_CFG_LOCK = 6;
  localparam logic [15:0] BLP_PERM_WORD_RST = 16'hffff;

  // ------------------------------------------------------------
  // Status bits driven by this block
  // ------------------------------------------------------------
  localparam int BLP_SR_BLOCK_LOCK = 1;
  localparam int BLP_SR_PROGRAM = 4;
  localparam int BLP_SR_ERASE = 5;

  // ------------------------------------------------------------
  // Block map
  // ------------------------------------------------------------
  localparam int BLP_NUM_BLOCKS = 131;
  localparam int BLP_NUM_PARAM = 4;

  // Host bus write as seen after the command interface
  typedef struct packed {
    logic valid;
    logic [7:0] blk;
    logic [7:0] ofs;
    logic [7:0] data;
  } blp_wr_s;

  // Array operation request from the write state machine
  typedef struct packed {
    logic valid;
    logic is_erase;
    logic [7:0] blk;
  } blp_op_s;

  typedef enum logic [1:0] {BLP_IDLE, BLP_SETUP, BLP_ID} blp_state_e;

endpackage

// ==== blp_block_lock.sv ====
// Purpose: Per-block lock latches, lock machine, permission and readout
// Assumes: Inputs synchronous to clock; power-down shares resetn
// Notes: Permanent lock word programming is accepted one word at a time

`timescale 1ns/100ps

// Contract
// RULE1: Reset low protects all, freezes latches
// RULE2: Low program supply protects all blocks
// RULE3: Otherwise only locked blocks are protected
// RULE4: Unlock clears latch unless hard lockdown
// RULE5: Decode 60h then 01h, D0h, 2Fh
// RULE6: Lockdown sets both latches
// RULE7: Pin low freezes locked-down blocks
// RULE8: Pin high allows unlock/relock of lockdown
// RULE9: Pin fall maps 111/110 states
// RULE10: Virtual lockdown reads locked; unlocks on high
// RULE11: Host locks unlocked blocks before pin low
// RULE12: Reset clears lockdown, sets lock latches
// RULE13: ID mode offset 2 returns latch bits
// RULE14: Lockdown readout cleared only by reset
// RULE15: Lock commands accepted in erase suspend
// RULE16: No lock commands during write suspend
// RULE17: Bad second byte sets bits 4,5
// RULE18: Permanent bits 2-5 disable write/erase
// RULE19: Bit map to parameter and main blocks
// RULE20: Config bit 6 freezes permanent bits
// RULE21: Permanent lock aborts with lock error
// RULE22: No permanent programming during suspended erase; code refuses only if the suspended block has a permanent bit
// RULE23: Permanent lock absent from status readout
// RULE24: Locked target aborts with lock error
// RULE25: Latches in flops, permission combinational
module blp_block_lock
  import blp_pkg::*;
#(
  parameter int NUM_BLOCKS = blp_pkg::BLP_NUM_BLOCKS
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Pins and straps
  input wire logic write_protect_n,
  input wire logic program_supply_ok,
  input wire logic top_boot,
  // Host writes and reads
  input wire blp_pkg::blp_wr_s host_wr,
  input wire logic [7:0] rd_blk,
  input wire logic [7:0] rd_ofs,
  output logic [15:0] rd_data,
  output logic id_mode,
  // Write state machine state
  input wire logic erase_suspended,
  input wire logic write_suspended,
  input wire logic [7:0] susp_blk,
  // Permanent lock word programming
  input wire logic perm_prog,
  input wire logic [15:0] perm_data,
  output logic perm_reject,
  // Array operation check
  input wire blp_pkg::blp_op_s op,
  output logic op_allowed,
  output logic op_abort,
  // Status bit sets (one cycle pulses)
  output logic sr_set_lock_err,
  output logic sr_set_program_err,
  output logic sr_set_erase_err
);
  import blp_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [NUM_BLOCKS-1:0] lock_latch_r, lock_latch_nxt;
  logic [NUM_BLOCKS-1:0] lockdown_latch_r, lockdown_latch_nxt;
  logic [15:0] perm_word_r = BLP_PERM_WORD_RST;
  logic [15:0] perm_word_nxt;
  blp_state_e state_r, state_nxt;
  logic wp_d_r;
  logic [15:0] rd_data_nxt;
  logic lock_err_nxt, prog_err_nxt, erase_err_nxt, abort_nxt;
  logic wp_fall;
  logic perm_ok;

  assign wp_fall = wp_d_r & ~write_protect_n;
  assign id_mode = (state_r == BLP_ID);

  // Map a block to its permanent lock bit, or none
  function automatic logic perm_locked(input logic [7:0] blk, input logic [15:0] w,
                                       input logic top);
    logic hit;
    int idx;
    hit = 1'b0;
    idx = int'(blk);
    // Parameter blocks share one bit; three main blocks one each
    if (!top && idx < BLP_NUM_PARAM)
      hit = ~w[BLP_BIT_PERM_PARAM]; // RULE19
    else if (top && idx >= NUM_BLOCKS - BLP_NUM_PARAM)
      hit = ~w[BLP_BIT_PERM_PARAM]; // RULE19
    else if (!top && idx >= BLP_NUM_PARAM && idx < BLP_NUM_PARAM + 3)
      hit = ~w[BLP_BIT_PERM_MAIN0 + idx - BLP_NUM_PARAM]; // RULE19
    else if (top && idx < NUM_BLOCKS - BLP_NUM_PARAM && idx >= NUM_BLOCKS - BLP_NUM_PARAM - 3)
      hit = ~w[BLP_BIT_PERM_MAIN0 + (NUM_BLOCKS - BLP_NUM_PARAM - 1 - idx)]; // RULE19
    return hit;
  endfunction

  // ------------------------------------------------------------
  // Write permission, purely combinational from latches, permanent lock word and pins
  // ------------------------------------------------------------
  always_comb
  begin
    op_allowed = 1'b0;
    if (resetn && program_supply_ok && int'(op.blk) < NUM_BLOCKS) // RULE1 RULE2
      op_allowed = ~lock_latch_r[op.blk] // RULE3 RULE24 RULE25
                   & ~(lockdown_latch_r[op.blk] & ~write_protect_n) // RULE9 RULE10
                   & ~perm_locked(op.blk, perm_word_r, top_boot); // RULE18 RULE21
  end

  // ------------------------------------------------------------
  // Command decode, latch updates, readout
  // ------------------------------------------------------------
  always_comb
  begin
    logic [7:0] b;
    b = host_wr.blk;
    lock_latch_nxt = lock_latch_r;
    lockdown_latch_nxt = lockdown_latch_r;
    perm_word_nxt = perm_word_r;
    state_nxt = state_r;
    lock_err_nxt = 1'b0;
    prog_err_nxt = 1'b0;
    erase_err_nxt = 1'b0;
    abort_nxt = 1'b0;
    perm_ok = 1'b0;
    // Pin moves between 111/011 and 110/010 leave the latches alone: the pin
    // level is folded into permission and readout instead, so a virtual
    // lockdown block (lockdown set, lock clear) is protected while the pin
    // is low and writable again the moment it rises, with no clock of delay.
    // Trade-off: 010 and 110 share one latch pattern and only the pin level
    // tells them apart, so the pin must be steady whenever it is sampled.
    // No latch update is needed here for either pin edge.
    if (host_wr.valid)
    begin
      case (state_r)
        BLP_SETUP:
        begin
          state_nxt = BLP_IDLE;
          if (write_suspended || int'(b) >= NUM_BLOCKS)
            state_nxt = BLP_IDLE; // RULE16
          else if (host_wr.data == BLP_CMD_LOCK)
            lock_latch_nxt[b] = lockdown_latch_r[b] && !write_protect_n ?
                                lock_latch_r[b] : 1'b1; // RULE5 RULE7 RULE8 RULE15
          else if (host_wr.data == BLP_CMD_UNLOCK)
          begin
            if (!(lockdown_latch_r[b] && !write_protect_n))
              lock_latch_nxt[b] = 1'b0; // RULE4 RULE8
          end
          else if (host_wr.data == BLP_CMD_LOCKDOWN)
          begin
            if (!(lockdown_latch_r[b] && !write_protect_n))
            begin
              lock_latch_nxt[b] = 1'b1; // RULE6
              lockdown_latch_nxt[b] = 1'b1; // RULE14
            end
          end
          else
          begin
            // Sequence error; the write state machine keeps these sticky
            prog_err_nxt = 1'b1; // RULE17
            erase_err_nxt = 1'b1; // RULE17
          end
        end
        BLP_IDLE, BLP_ID:
        begin
          if (host_wr.data == BLP_CMD_CFG_SETUP)
            state_nxt = BLP_SETUP; // RULE5
          else if (host_wr.data == BLP_CMD_READ_ID)
            state_nxt = BLP_ID; // RULE13
          else if (host_wr.data == BLP_CMD_READ_ARRAY)
            state_nxt = BLP_IDLE;
        end
        default: state_nxt = BLP_IDLE;
      endcase
    end
    // Permanent lock word: cells only go from one to zero
    if (perm_prog)
    begin
      perm_ok = 1'b1;
      if (erase_suspended && perm_locked(susp_blk, 16'h0000, top_boot))
        perm_ok = 1'b0; // RULE22
      if (!perm_word_r[BLP_BIT_CFG_LOCK] &&
          ((perm_data[BLP_BIT_PERM_MAIN2:BLP_BIT_PERM_PARAM] &
            perm_word_r[BLP_BIT_PERM_MAIN2:BLP_BIT_PERM_PARAM]) !=
           perm_word_r[BLP_BIT_PERM_MAIN2:BLP_BIT_PERM_PARAM]))
        perm_ok = 1'b0; // RULE20
      if (perm_ok)
        perm_word_nxt = perm_word_r & perm_data;
      else
      begin
        prog_err_nxt = 1'b1;
        lock_err_nxt = 1'b1;
      end
    end
    // Array operations refused by protection
    if (op.valid && !op_allowed)
    begin
      abort_nxt = 1'b1;
      lock_err_nxt = program_supply_ok | lock_err_nxt; // RULE21 RULE24
    end
    // Readout in identifier mode; permanent state is not mixed in
    rd_data_nxt = 16'h0000;
    if (state_nxt == BLP_ID && rd_ofs == BLP_OFS_LOCK_STATUS && int'(rd_blk) < NUM_BLOCKS)
    begin
      rd_data_nxt[BLP_BIT_LOCK_READOUT] = lock_latch_nxt[rd_blk] |
        (lockdown_latch_nxt[rd_blk] & ~write_protect_n); // RULE10 RULE13 RULE23
      rd_data_nxt[BLP_BIT_LOCKDOWN_READOUT] = lockdown_latch_nxt[rd_blk]; // RULE13
    end
    else if (state_nxt == BLP_ID && rd_ofs == BLP_OFS_PERM_WORD)
      rd_data_nxt = perm_word_nxt;
  end

  // Latches; reset also models power-down
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      lock_latch_r <= '1; // RULE12 RULE1 RULE4
      lockdown_latch_r <= '0; // RULE12 RULE14
      state_r <= BLP_IDLE;
      wp_d_r <= 1'b0;
      rd_data <= 16'h0000;
      op_abort <= 1'b0;
      sr_set_lock_err <= 1'b0;
      sr_set_program_err <= 1'b0;
      sr_set_erase_err <= 1'b0;
    end
    else
    begin
      lock_latch_r <= lock_latch_nxt;
      lockdown_latch_r <= lockdown_latch_nxt;
      state_r <= state_nxt;
      wp_d_r <= write_protect_n;
      rd_data <= rd_data_nxt;
      op_abort <= abort_nxt;
      sr_set_lock_err <= lock_err_nxt;
      sr_set_program_err <= prog_err_nxt;
      sr_set_erase_err <= erase_err_nxt;
    end
  end

  // Nonvolatile word: not cleared by reset
  always_ff @(posedge clock)
  begin
    perm_word_r <= perm_word_nxt;
  end

  // Power-up value comes from the declaration; reset never sets the cells

  assign perm_reject = perm_prog & ~perm_ok;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  low_supply_a: assert property (!program_supply_ok |-> !op_allowed) // RULE2
    else $error("op allowed under low supply");
  lock_blocks_a: assert property (op.valid && program_supply_ok &&
    int'(op.blk) < NUM_BLOCKS && lock_latch_r[op.blk]
    |=> op_abort && sr_set_lock_err) // RULE24
    else $error("locked block not aborted");
  ld_sets_both_a: assert property (host_wr.valid && state_r == BLP_SETUP &&
    host_wr.data == BLP_CMD_LOCKDOWN && !write_suspended &&
    (write_protect_n || !lockdown_latch_r[host_wr.blk]) &&
    int'(host_wr.blk) < NUM_BLOCKS |=> lockdown_latch_r[$past(host_wr.blk)] &&
    lock_latch_r[$past(host_wr.blk)]) // RULE6
    else $error("lockdown did not set latches");
  ld_sticky_a: assert property (|lockdown_latch_r |=>
    ((lockdown_latch_r & $past(lockdown_latch_r)) == $past(lockdown_latch_r))) // RULE14
    else $error("lockdown latch cleared");
  hard_ld_a: assert property (host_wr.valid && state_r == BLP_SETUP && !write_protect_n &&
    int'(host_wr.blk) < NUM_BLOCKS && lockdown_latch_r[host_wr.blk] |=>
    $stable(lock_latch_r) && $stable(lockdown_latch_r)) // RULE7
    else $error("locked-down block changed");
  wsusp_a: assert property (write_suspended && state_r == BLP_SETUP && host_wr.valid
    |=> $stable(lock_latch_r)) // RULE16
    else $error("lock change during write suspend");
  bad_seq_a: assert property (host_wr.valid && state_r == BLP_SETUP && !write_suspended &&
    int'(host_wr.blk) < NUM_BLOCKS && host_wr.data != BLP_CMD_LOCK &&
    host_wr.data != BLP_CMD_UNLOCK && host_wr.data != BLP_CMD_LOCKDOWN
    |=> sr_set_program_err && sr_set_erase_err) // RULE17
    else $error("bad sequence not flagged");
  virt_lock_a: assert property (int'(op.blk) < NUM_BLOCKS && !write_protect_n &&
    lockdown_latch_r[op.blk] |-> !op_allowed) // RULE10
    else $error("lockdown block writable while pin low");

  cov_lockdown_c: cover property (host_wr.valid && state_r == BLP_SETUP &&
    host_wr.data == BLP_CMD_LOCKDOWN);
  cov_wp_fall_c: cover property (wp_fall && |lockdown_latch_r);
  cov_abort_c: cover property (op_abort);
  cov_perm_c: cover property (perm_prog && perm_ok);

endmodule

// ==== blp_host_model.sv ====
// Purpose: Host controller model that issues command writes
// Assumes: Writes launched just after a rising clock edge
// Notes: Idle bus carries inverted bytes so stale values never pass
`timescale 1ns/100ps
module blp_host_model
  import blp_pkg::*;
(
  // Clock
  input wire logic clock,
  // Command bus
  output blp_pkg::blp_wr_s host_wr
);
  // ----------------------------------------
  // Command writes
  // ----------------------------------------
  initial host_wr = '0;

  // One write, valid held for exactly one sampling edge
  task automatic wr(input logic [7:0] blk, input logic [7:0] data);
    @(posedge clock);
    host_wr <= '{1'b1, blk, 8'h00, data};
    @(posedge clock);
    host_wr <= '{1'b0, ~blk, 8'hff, ~data};
  endtask

  // Setup byte then action byte, never split
  task automatic lock_seq(input logic [7:0] blk, input logic [7:0] act);
    wr(blk, BLP_CMD_CFG_SETUP);
    wr(blk, act);
  endtask
endmodule

// ==== tb_block_lock_protection.sv ====
// Purpose: Self-checking bench for the block lock protection logic
// Assumes: Bottom boot strap until the final top boot checks, 10 ns clock
// Notes: Reads go through identifier mode, re-entered before each read
`timescale 1ns/100ps
module tb_block_lock_protection;
  import blp_pkg::*;
  logic clock, resetn, wp_n, sup_ok, top_boot, e_susp, w_susp, perm_prog;
  logic id_mode, perm_reject, op_allowed, op_abort, sr_lock, sr_prog, sr_erase;
  logic [7:0] rd_blk, rd_ofs, susp_blk;
  logic [15:0] rd_data, perm_data;
  blp_wr_s host_wr;
  blp_op_s op;
  int fail_count, cmp_count;

  // ----------------------------------------
  // Clock, host model and design
  // ----------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  blp_host_model host (.clock(clock), .host_wr(host_wr));

  blp_block_lock uut (.clock(clock), .resetn(resetn), .write_protect_n(wp_n),
    .program_supply_ok(sup_ok), .top_boot(top_boot), .host_wr(host_wr),
    .rd_blk(rd_blk), .rd_ofs(rd_ofs), .rd_data(rd_data), .id_mode(id_mode),
    .erase_suspended(e_susp), .write_suspended(w_susp), .susp_blk(susp_blk),
    .perm_prog(perm_prog), .perm_data(perm_data), .perm_reject(perm_reject),
    .op(op), .op_allowed(op_allowed), .op_abort(op_abort),
    .sr_set_lock_err(sr_lock), .sr_set_program_err(sr_prog),
    .sr_set_erase_err(sr_erase));

  // ----------------------------------------
  // Check and access tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Read one identifier word; rd_data lands one cycle after the address
  task automatic rd(input logic [7:0] blk, input logic [7:0] ofs, input logic [15:0] e);
    host.wr(8'h00, BLP_CMD_READ_ID);
    #1 chk("id_mode", 16'h1, {15'h0, id_mode});
    @(posedge clock);
    rd_blk <= blk;
    rd_ofs <= ofs;
    @(posedge clock);
    #1 chk("rd_data", e, rd_data);
  endtask

  task automatic st(input logic [7:0] blk, input logic [15:0] e);
    rd(blk, BLP_OFS_LOCK_STATUS, e);
  endtask

  task automatic allow(input logic [7:0] blk, input logic e);
    @(posedge clock);
    op <= '{1'b0, 1'b0, blk};
    @(posedge clock);
    #1 chk("op_allowed", {15'h0, e}, {15'h0, op_allowed});
  endtask

  // Refused op gives abort and lock error pulses the cycle after
  task automatic abort(input logic [7:0] blk);
    @(posedge clock);
    op <= '{1'b1, 1'b1, blk};
    @(posedge clock);
    op.valid <= 1'b0;
    #1 chk("op_abort", 16'h1, {15'h0, op_abort});
    chk("sr_lock", 16'h1, {15'h0, sr_lock});
  endtask

  task automatic perm(input logic [15:0] d, input logic e);
    @(posedge clock);
    perm_prog <= 1'b1;
    perm_data <= d;
    #1 chk("perm_reject", {15'h0, e}, {15'h0, perm_reject});
    @(posedge clock);
    perm_prog <= 1'b0;
    #1 chk("sr_prog", {15'h0, e}, {15'h0, sr_prog});
    chk("sr_lock", {15'h0, e}, {15'h0, sr_lock});
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog, far beyond the under two hundred cycles the tests need
  initial
  begin
    #200000;
    fail_count++;
    end_of_test();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    {resetn, wp_n, top_boot, e_susp, w_susp, perm_prog} = '0;
    sup_ok = 1'b1;
    {rd_blk, rd_ofs, susp_blk, perm_data} = '0;
    op = '0;
    fail_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    st(8'd5, 16'h0001);
    allow(8'd5, 1'b0);
    abort(8'd5);
    host.lock_seq(8'd5, BLP_CMD_UNLOCK);
    st(8'd5, 16'h0000);
    allow(8'd5, 1'b1);
    @(posedge clock) sup_ok <= 1'b0;
    allow(8'd5, 1'b0);
    @(posedge clock) sup_ok <= 1'b1;
    host.lock_seq(8'd5, BLP_CMD_LOCK);
    st(8'd5, 16'h0001);
    host.lock_seq(8'd5, BLP_CMD_LOCKDOWN);
    st(8'd5, 16'h0003);
    host.lock_seq(8'd5, BLP_CMD_UNLOCK);
    st(8'd5, 16'h0003);
    host.lock_seq(8'd6, BLP_CMD_LOCKDOWN);
    @(posedge clock) wp_n <= 1'b1;
    host.lock_seq(8'd5, BLP_CMD_UNLOCK);
    st(8'd5, 16'h0002);
    allow(8'd5, 1'b1);
    host.lock_seq(8'd5, BLP_CMD_LOCK);
    host.lock_seq(8'd6, BLP_CMD_UNLOCK);
    @(posedge clock) wp_n <= 1'b0;
    st(8'd5, 16'h0003);
    st(8'd6, 16'h0003);
    allow(8'd6, 1'b0);
    @(posedge clock) wp_n <= 1'b1;
    allow(8'd6, 1'b1);
    @(posedge clock) w_susp <= 1'b1;
    host.lock_seq(8'd6, BLP_CMD_LOCK);
    st(8'd6, 16'h0002);
    @(posedge clock) {w_susp, e_susp, susp_blk} <= {1'b0, 1'b1, 8'd6};
    host.lock_seq(8'd6, BLP_CMD_LOCK);
    st(8'd6, 16'h0003);
    @(posedge clock) e_susp <= 1'b0;
    host.wr(8'd7, BLP_CMD_CFG_SETUP);
    host.wr(8'd7, 8'h55);
    #1 chk("sr_prog", 16'h1, {15'h0, sr_prog});
    chk("sr_erase", 16'h1, {15'h0, sr_erase});
    host.lock_seq(8'd0, BLP_CMD_UNLOCK);
    host.lock_seq(8'd4, BLP_CMD_UNLOCK);
    @(posedge clock) {e_susp, susp_blk} <= {1'b1, 8'd4};
    perm(16'hfff3, 1'b1);
    @(posedge clock) e_susp <= 1'b0;
    allow(8'd4, 1'b1);
    perm(16'hfffb, 1'b0);
    allow(8'd0, 1'b0);
    allow(8'd3, 1'b0);
    allow(8'd4, 1'b1);
    st(8'd0, 16'h0000);
    abort(8'd0);
    perm(16'hffbb, 1'b0);
    perm(16'hffb3, 1'b1);
    rd(8'd0, BLP_OFS_PERM_WORD, 16'hffbb);
    @(posedge clock) resetn <= 1'b0;
    allow(8'd4, 1'b0);
    @(posedge clock) resetn <= 1'b1;
    st(8'd4, 16'h0001);
    host.lock_seq(8'd127, BLP_CMD_UNLOCK);
    host.lock_seq(8'd126, BLP_CMD_UNLOCK);
    host.lock_seq(8'd0, BLP_CMD_UNLOCK);
    @(posedge clock) top_boot <= 1'b1;
    allow(8'd127, 1'b0);
    allow(8'd126, 1'b1);
    allow(8'd0, 1'b1);
    end_of_test();
  end
endmodule
